// [pkg/rau_pkg.sv]
package rau_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] OFF_FG        = 8'h00;
    localparam logic [7:0] OFF_BG        = 8'h04;
    localparam logic [7:0] OFF_ROP       = 8'h08;
    localparam logic [7:0] OFF_PLANE     = 8'h0c;
    localparam logic [7:0] OFF_PIXEL     = 8'h10;
    localparam logic [7:0] OFF_ALIGN     = 8'h14;
    localparam logic [7:0] OFF_CONFIG    = 8'h18;
    localparam logic [7:0] OFF_STATUS    = 8'h1c;
    localparam logic [7:0] OFF_PAT_BASE  = 8'h20;
    localparam logic [7:0] OFF_PAT_LAST  = 8'h3c;
    // ==========================================
    // geometry
    localparam int NPIX = 16;
    localparam int PIXW = 8;
    localparam int NSUB = 4;
    localparam int NPAT = 8;
    // ==========================================
    // field positions
    localparam int ROP_PM_LSB   = 30;
    localparam int ROP_XM_LSB   = 28;
    localparam int ROP_PT_LSB   = 26;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_LE_BIT   = 2;
    localparam int CFG_SUB_BIT  = 3;
    localparam int ALIGN_X_LSB  = 16;
    localparam int ALIGN_Y_LSB  = 0;
    localparam int STAT_INV_BIT = 0;
    // ==========================================
    // encodings
    localparam logic [1:0] MODE_EIGHT = 2'h1;
    localparam logic [1:0] MODE_ONE   = 2'h2;
    localparam logic [1:0] MODE_SUB   = 2'h3;
    localparam logic [1:0] OVR_IGNORE = 2'h0;
    localparam logic [1:0] OVR_ZERO   = 2'h1;
    localparam logic [1:0] OVR_ONES   = 2'h2;
    localparam logic [1:0] OVR_REG    = 2'h3;
    localparam logic [3:0] LOP_SDEC1  = 4'h0;
    localparam logic [3:0] LOP_SSUBS  = 4'h2;
    localparam logic [3:0] LOP_ADD1   = 4'h5;
    localparam logic [3:0] LOP_ADDS   = 4'h6;
    localparam logic [3:0] LOP_SSUBN  = 4'h8;
    localparam logic [3:0] LOP_ADDN   = 4'h9;
    localparam logic [3:0] LOP_KEEP   = 4'ha;
    localparam logic [3:0] LOP_SADDN  = 4'hb;
    localparam logic [3:0] LOP_SADDS  = 4'he;
    localparam logic [3:0] LOP_SINC1  = 4'hf;
    // ==========================================
    // values
    localparam logic [6:0]  INT_MAX      = 7'h7f;
    localparam logic [6:0]  FLAT_WEIGHT  = 7'h10;
    localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;
endpackage

// [core/rau_core.sv]
// Behaviour
// - colour bits 7..0 per plane; mono bit0
// - subpixel mode ignores colour bits 7..1
// - all sixteen pixels processed in parallel
// - four 4-bit codes in low sixteen bits
// - plane fg/bg bits pick its code; subpixel mode uses plane 0 bits for all planes
// - boolean code is s/d truth table
// - colour linear ops use pixel intensity
// - subpixel source bits are pixel subpixels
// - subpixel altered to s,~s,1 then clipped
// - source is sum of set weights
// - six linear codes are not performed
// - saturating codes same in both modes
// - wrapping codes add or subtract by mode
// - bit 7 keeps the carry out
// - linear code uses plane 0 colours
// - overrides never alter stored registers
// - override fields select ignore/zero/ones/register
// - plane gate enables plane writes
// - big-endian pixel gate bit31 leftmost
// - little-endian pixel gate bit0 leftmost
// - pattern rows indexed by y offset
// - pattern column by x offset, msb left
// - disabled pattern substitutes ones or zeros
// - pattern per pixel, or per subpixel
`timescale 1ns/1ns
`default_nettype none
module rau_core
    import rau_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         op_valid,
    input  wire logic         op_linear,
    input  wire logic         op_use_pattern,
    input  wire logic [10:0]  op_x,
    input  wire logic [10:0]  op_y,
    input  wire logic [127:0] src_pixels,
    input  wire logic [63:0]  src_subpixels,
    input  wire logic [63:0]  clip_subpixels,
    input  wire logic [127:0] dst_pixels,
    output logic              result_valid,
    output logic      [127:0] result_pixels,
    output logic      [15:0]  result_pixel_we,
    output logic      [7:0]   result_plane_we
);

    // ==========================================
    // helpers
    function automatic logic [31:0] apply_override(input logic [1:0] sel, input logic [31:0] stored);
        logic [31:0] r;
        r = stored;
        case (sel)
            OVR_ZERO: r = 32'h0000_0000;
            OVR_ONES: r = 32'hffff_ffff;
            default:  r = stored;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] pick_code(input logic [31:0] rop, input logic f, input logic b);
        logic [3:0] c;
        c = 4'h0;
        case ({f, b})
            2'b00:   c = rop[3:0];
            2'b01:   c = rop[7:4];
            2'b10:   c = rop[11:8];
            default: c = rop[15:12];
        endcase
        return c;
    endfunction

    // returns {supported, carry, value}; carry is the add/subtract carry out
    function automatic logic [8:0] lin_calc(input logic [3:0] code, input logic [6:0] d,
                                            input logic [6:0] opnd, input logic unplot);
        logic [7:0] sum;
        logic [7:0] dif;
        logic [8:0] r;
        sum = {1'b0, d} + {1'b0, opnd};
        dif = {1'b0, d} - {1'b0, opnd};
        r   = {1'b1, 1'b0, d};
        case (code)
            LOP_SDEC1, LOP_SSUBS, LOP_SSUBN: r = {1'b1, dif[7], dif[7] ? 7'h00 : dif[6:0]};
            LOP_SADDN, LOP_SADDS, LOP_SINC1: r = {1'b1, sum[7], sum[7] ? INT_MAX : sum[6:0]};
            LOP_ADD1, LOP_ADDS, LOP_ADDN:    r = unplot ? {1'b1, dif} : {1'b1, sum};
            LOP_KEEP:                        r = {1'b1, 1'b0, d};
            default:                         r = {1'b0, 1'b0, d};
        endcase
        return r;
    endfunction

    // operand kind: 0 constant one, 1 source, 2 inverted source
    function automatic logic [1:0] lin_kind(input logic [3:0] code);
        logic [1:0] k;
        k = 2'd0;
        case (code)
            LOP_SSUBS, LOP_ADDS, LOP_SADDS: k = 2'd1;
            LOP_SSUBN, LOP_ADDN, LOP_SADDN: k = 2'd2;
            default:                        k = 2'd0;
        endcase
        return k;
    endfunction

    // ==========================================
    // register state
    logic [31:0]  fg_reg, fg_next;
    logic [31:0]  bg_reg, bg_next;
    logic [31:0]  rop_reg, rop_next;
    logic [31:0]  plane_reg, plane_next;
    logic [31:0]  pixel_reg, pixel_next;
    logic [31:0]  align_reg, align_next;
    logic [31:0]  config_reg, config_next;
    logic         inv_reg, inv_next;
    logic [31:0]  pat_reg [NPAT];
    logic [31:0]  pat_next [NPAT];
    logic         valid_reg, valid_next;
    logic [127:0] res_reg, res_next;
    logic [15:0]  pwe_reg, pwe_next;
    logic [7:0]   plwe_reg, plwe_next;

    logic         wr_en;
    logic         mapped;
    logic [31:0]  rd_data;
    logic         inv_set;
    logic [2:0]   pat_idx;

    assign wr_en   = psel && penable && pwrite;
    assign pat_idx = paddr[4:2];
    assign pready  = 1'b1;

    // ==========================================
    // read decode
    always_comb begin
        mapped  = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (paddr >= OFF_PAT_BASE && paddr <= OFF_PAT_LAST) begin
            rd_data = pat_reg[pat_idx];
        end else begin
            case (paddr)
                OFF_FG:     rd_data = fg_reg;
                OFF_BG:     rd_data = bg_reg;
                OFF_ROP:    rd_data = rop_reg;
                OFF_PLANE:  rd_data = plane_reg;
                OFF_PIXEL:  rd_data = pixel_reg;
                OFF_ALIGN:  rd_data = align_reg;
                OFF_CONFIG: rd_data = config_reg;
                OFF_STATUS: rd_data = {31'h0000_0000, inv_reg};
                default:    mapped  = 1'b0;
            endcase
        end
    end

    assign prdata  = (psel && !pwrite && mapped) ? rd_data : 32'h0000_0000;
    assign pslverr = psel && penable && !mapped;

    // ==========================================
    // datapath
    logic [1:0]   mode;
    logic         sub_mode;
    logic         little_end;
    logic         unplot;
    logic [31:0]  eff_plane;
    logic [31:0]  eff_pixel;
    logic [1:0]   pat_sel;
    logic [3:0]   ax;
    logic [3:0]   ay;
    logic [3:0]   prow;
    logic [31:0]  pword;
    logic [15:0]  rowbits;
    logic [10:0]  xi;
    logic [4:0]   midx;
    logic [3:0]   col;
    logic         pbit;
    logic [7:0]   s;
    logic [7:0]   d;
    logic [7:0]   bres;
    logic [3:0]   code;
    logic [3:0]   lcode;
    logic [1:0]   kind;
    logic         sbit;
    logic [8:0]   acc;
    logic [6:0]   opnd;
    logic [8:0]   lr;
    logic [127:0] dp_res;
    logic [15:0]  dp_pwe;
    logic         dp_inv;

    assign mode       = config_reg[CFG_MODE_LSB +: 2];
    assign sub_mode   = (mode == MODE_SUB);
    assign little_end = config_reg[CFG_LE_BIT];
    assign unplot     = config_reg[CFG_SUB_BIT];
    assign ax         = align_reg[ALIGN_X_LSB +: 4];
    assign ay         = align_reg[ALIGN_Y_LSB +: 4];
    assign pat_sel    = rop_reg[ROP_PT_LSB +: 2];
    assign eff_plane  = apply_override(rop_reg[ROP_PM_LSB +: 2], plane_reg);
    assign eff_pixel  = apply_override(rop_reg[ROP_XM_LSB +: 2], pixel_reg);
    assign prow       = op_y[3:0] - ay;
    assign pword      = pat_reg[prow[3:1]];
    assign rowbits    = prow[0] ? pword[15:0] : pword[31:16];
    assign lcode      = pick_code(rop_reg, fg_reg[0], bg_reg[0]);
    assign kind       = lin_kind(lcode);

    always_comb begin
        dp_res = 128'h0;
        dp_pwe = 16'h0000;
        dp_inv = 1'b0;
        xi     = 11'h000;
        midx   = 5'h00;
        col    = 4'h0;
        pbit   = 1'b0;
        s      = 8'h00;
        d      = 8'h00;
        bres   = 8'h00;
        code   = 4'h0;
        sbit   = 1'b0;
        acc    = 9'h000;
        opnd   = 7'h00;
        lr     = 9'h000;
        for (int i = 0; i < NPIX; i++) begin
            xi   = op_x + 11'(i);
            midx = xi[4:0];
            dp_pwe[i] = little_end ? eff_pixel[midx] : eff_pixel[5'd31 - midx];
            col  = xi[3:0] - ax;
            pbit = rowbits[4'd15 - col];
            if (pat_sel == OVR_ZERO) begin
                pbit = 1'b0;
            end else if (pat_sel == OVR_ONES) begin
                pbit = 1'b1;
            end
            d = dst_pixels[i*PIXW +: PIXW];
            if (op_use_pattern) begin
                s = {8{pbit}};
            end else if (mode != MODE_EIGHT) begin
                s = {8{src_pixels[i*PIXW]}};
            end else begin
                s = src_pixels[i*PIXW +: PIXW];
            end
            for (int p = 0; p < PIXW; p++) begin
                if (sub_mode) begin
                    code = lcode;
                end else begin
                    code = pick_code(rop_reg, fg_reg[p], bg_reg[p]);
                end
                bres[p] = code[{s[p], d[p]}];
            end
            // subpixel filter over one subpixel line of this pixel
            acc = 9'h000;
            for (int j = 0; j < NSUB; j++) begin
                if (op_use_pattern) begin
                    sbit = rowbits[4'd15 - ({xi[1:0], 2'(j)} - ax)];
                    if (pat_sel == OVR_ZERO) begin
                        sbit = 1'b0;
                    end else if (pat_sel == OVR_ONES) begin
                        sbit = 1'b1;
                    end
                end else begin
                    sbit = src_subpixels[i*NSUB + j];
                end
                if (kind == 2'd2) begin
                    sbit = ~sbit;
                end else if (kind == 2'd0) begin
                    sbit = 1'b1;
                end
                if (sbit && clip_subpixels[i*NSUB + j]) begin
                    acc = acc + {2'b00, FLAT_WEIGHT};
                end
            end
            if (sub_mode) begin
                opnd = (acc > {2'b00, INT_MAX}) ? INT_MAX : acc[6:0];
            end else if (kind == 2'd1) begin
                opnd = s[6:0];
            end else if (kind == 2'd2) begin
                opnd = ~s[6:0];
            end else begin
                opnd = 7'h01;
            end
            lr = lin_calc(lcode, d[6:0], opnd, unplot);
            if (op_linear) begin
                // keep and refused codes leave the whole pixel, direction bit included, untouched
                dp_res[i*PIXW +: PIXW] = (lr[8] && lcode != LOP_KEEP) ? lr[7:0] : d;
                dp_inv = dp_inv | ~lr[8];
            end else begin
                dp_res[i*PIXW +: PIXW] = bres;
            end
        end
    end

    // ==========================================
    // next state
    assign inv_set = op_valid && op_linear && dp_inv;

    always_comb begin
        fg_next     = fg_reg;
        bg_next     = bg_reg;
        rop_next    = rop_reg;
        plane_next  = plane_reg;
        pixel_next  = pixel_reg;
        align_next  = align_reg;
        config_next = config_reg;
        inv_next    = inv_reg;
        for (int k = 0; k < NPAT; k++) begin
            pat_next[k] = pat_reg[k];
        end
        if (wr_en && mapped) begin
            if (paddr >= OFF_PAT_BASE) begin
                pat_next[pat_idx] = pwdata;
            end else begin
                case (paddr)
                    OFF_FG:     fg_next     = {24'h000000, pwdata[7:0]};
                    OFF_BG:     bg_next     = {24'h000000, pwdata[7:0]};
                    OFF_ROP:    rop_next    = pwdata;
                    OFF_PLANE:  plane_next  = {24'h000000, pwdata[7:0]};
                    OFF_PIXEL:  pixel_next  = pwdata;
                    OFF_ALIGN:  align_next  = {12'h000, pwdata[19:16], 12'h000, pwdata[3:0]};
                    OFF_CONFIG: config_next = {28'h0000000, pwdata[3:0]};
                    OFF_STATUS: inv_next    = inv_reg & ~pwdata[STAT_INV_BIT];
                    default:    inv_next    = inv_reg;
                endcase
            end
        end
        if (inv_set) begin
            inv_next = 1'b1;
        end
        valid_next = op_valid;
        res_next   = op_valid ? dp_res : res_reg;
        pwe_next   = op_valid ? dp_pwe : 16'h0000;
        plwe_next  = op_valid ? eff_plane[7:0] : 8'h00;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fg_reg     <= RESET_ZERO;
            bg_reg     <= RESET_ZERO;
            rop_reg    <= RESET_ZERO;
            plane_reg  <= RESET_ZERO;
            pixel_reg  <= RESET_ZERO;
            align_reg  <= RESET_ZERO;
            config_reg <= CONFIG_RESET;
            inv_reg    <= 1'b0;
            for (int k = 0; k < NPAT; k++) begin
                pat_reg[k] <= RESET_ZERO;
            end
            valid_reg  <= 1'b0;
            res_reg    <= 128'h0;
            pwe_reg    <= 16'h0000;
            plwe_reg   <= 8'h00;
        end else begin
            fg_reg     <= fg_next;
            bg_reg     <= bg_next;
            rop_reg    <= rop_next;
            plane_reg  <= plane_next;
            pixel_reg  <= pixel_next;
            align_reg  <= align_next;
            config_reg <= config_next;
            inv_reg    <= inv_next;
            for (int k = 0; k < NPAT; k++) begin
                pat_reg[k] <= pat_next[k];
            end
            valid_reg  <= valid_next;
            res_reg    <= res_next;
            pwe_reg    <= pwe_next;
            plwe_reg   <= plwe_next;
        end
    end

    assign result_valid    = valid_reg;
    assign result_pixels   = res_reg;
    assign result_pixel_we = pwe_reg;
    assign result_plane_we = plwe_reg;

endmodule
`default_nettype wire

// [tb/rau_vram.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// one frame buffer word, written through plane and pixel gates
module rau_vram (
    input  wire logic         sys_clk,
    input  wire logic         ld,
    input  wire logic [127:0] ld_data,
    input  wire logic         result_valid,
    input  wire logic [127:0] result_pixels,
    input  wire logic [15:0]  result_pixel_we,
    input  wire logic [7:0]   result_plane_we,
    output logic      [127:0] dst_pixels
);
    always_ff @(posedge sys_clk) begin
        if (ld) begin
            dst_pixels <= ld_data;
        end else if (result_valid) begin
            for (int i = 0; i < 16; i++) begin
                if (result_pixel_we[i]) begin
                    dst_pixels[8*i +: 8] <= (result_pixels[8*i +: 8] & result_plane_we)
                                          | (dst_pixels[8*i +: 8] & ~result_plane_we);
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/rau_core_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module rau_core_chk
    import rau_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         rst,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         op_valid,
    input wire logic         result_valid,
    input wire logic [127:0] result_pixels,
    input wire logic [15:0]  result_pixel_we,
    input wire logic [7:0]   result_plane_we
);
    // ==========================================
    // bus and datapath timing
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_ready_high: assert property (psel |-> pready)
        else $error("pready low during transfer");
    a_err_unaligned: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    a_err_range: assert property (psel && penable && paddr > OFF_PAT_LAST |-> pslverr)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= OFF_PAT_LAST |-> !pslverr)
        else $error("mapped access refused");
    a_err_quiet: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data on refused access");
    a_result_next: assert property (op_valid |=> result_valid)
        else $error("result missing after operation");
    a_result_only: assert property (!op_valid |=> !result_valid)
        else $error("result without operation");
    a_gate_idle: assert property (!result_valid |-> result_pixel_we == 16'h0 && result_plane_we == 8'h0)
        else $error("write enable outside result cycle");
    a_pixels_held: assert property (!op_valid |=> $stable(result_pixels))
        else $error("result pixels changed without operation");
endmodule
bind rau_core rau_core_chk chk (.sys_clk, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
                                .op_valid, .result_valid, .result_pixels, .result_pixel_we, .result_plane_we);
`default_nettype wire

// [tb/rau_core_test.sv]
`timescale 1ns/1ns
`default_nettype none
module rau_core_test
    import rau_pkg::*;
    ;
    localparam logic [127:0] S0 = 128'hff00_f0f0_cccc_aaaa_0f0f_3c3c_5a5a_0123;
    localparam logic [127:0] S1 = 128'h017f_0500_4041_7f10_6a0a_ff00_2255_8013;
    localparam logic [127:0] D0 = 128'h7f00_7e01_403f_1070_05ff_80c0_3366_997a;
    localparam logic [63:0]  SS = 64'hf731_0f0f_ffff_0001;
    localparam logic [63:0]  SC = 64'hffff_0ff0_f0f0_ffff;
    localparam logic [15:0]  PR = 16'ha5c3;
    logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr, erv;
    logic         op_valid, op_linear, op_use_pattern, result_valid, ld;
    logic [7:0]   paddr, result_plane_we, plw;
    logic [10:0]  op_x, op_y;
    logic [15:0]  result_pixel_we, pw;
    logic [31:0]  pwdata, prdata, rdv;
    logic [63:0]  src_subpixels, clip_subpixels;
    logic [127:0] src_pixels, dst_pixels, result_pixels, ld_data, rp, e;
    int           n_fail = 0;
    int           cmp_count = 0;

    rau_core dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                  .op_valid, .op_linear, .op_use_pattern, .op_x, .op_y, .src_pixels, .src_subpixels,
                  .clip_subpixels, .dst_pixels, .result_valid, .result_pixels, .result_pixel_we,
                  .result_plane_we);
    rau_vram vram (.sys_clk, .ld, .ld_data, .result_valid, .result_pixels, .result_pixel_we,
                   .result_plane_we, .dst_pixels);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ==========================================
    // shared tasks
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] x, g);
        cmp_count++;
        if (g !== x) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) n_fail++;
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
        bus(1'b0, a, 32'h0);
        chk(nm, 128'(x), 128'(rdv));
        chk("pslverr", 128'(xe), 128'(erv));
    endtask

    task automatic op(input logic lin, pat, input logic [10:0] x, y, input logic [127:0] s, d);
        @(posedge sys_clk);
        ld <= 1'b1;
        ld_data <= d;
        @(posedge sys_clk);
        ld <= 1'b0;
        op_valid <= 1'b1;
        op_linear <= lin;
        op_use_pattern <= pat;
        op_x <= x;
        op_y <= y;
        src_pixels <= s;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        @(negedge sys_clk);
        chk("result_valid", 128'h1, 128'(result_valid));
        rp = result_pixels;
        pw = result_pixel_we;
        plw = result_plane_we;
        @(negedge sys_clk);
    endtask

    function automatic logic [127:0] bexp(input logic [15:0] r, input logic [127:0] s, d);
        // plane p: foreground bit is p[2] (0xf0), background bit is p[1] (0xcc)
        for (int k = 0; k < 128; k++) bexp[k] = r[{k[2], k[1], s[k], d[k]}];
    endfunction

    function automatic logic [7:0] lexp(input logic [3:0] c, input logic u, input logic [7:0] d, s);
        logic [7:0] o;
        logic [7:0] r;
        logic       sb;
        o = c inside {0, 5, 15} ? 8'h1 : c inside {8, 9, 11} ? {1'b0, ~s[6:0]} : {1'b0, s[6:0]};
        sb = c inside {0, 2, 8} || (c inside {5, 6, 9} && u);
        r = sb ? {1'b0, d[6:0]} - o : {1'b0, d[6:0]} + o;
        if (!(c inside {5, 6, 9}) && r[7]) r[6:0] = sb ? 7'h0 : INT_MAX;
        lexp = c inside {1, 3, 4, 7, 10, 12, 13} ? d : r;
    endfunction

    // ==========================================
    // scenarios
    task automatic t_regs;
        rchk("config", OFF_CONFIG, CONFIG_RESET, 1'b0);
        wr(OFF_FG, 32'h1ff);
        rchk("fg", OFF_FG, 32'hff, 1'b0);
        wr(OFF_ROP, 32'hdead_beef);
        rchk("rop", OFF_ROP, 32'hdead_beef, 1'b0);
        rchk("unmapped", 8'h40, 32'h0, 1'b1);
        rchk("unaligned", 8'h02, 32'h0, 1'b1);
    endtask

    task automatic t_bool;
        logic [15:0] r;
        wr(OFF_FG, 32'hf0);
        wr(OFF_BG, 32'hcc);
        wr(OFF_PLANE, 32'hff);
        wr(OFF_PIXEL, 32'hffff_ffff);
        for (int c = 0; c < 16; c++) begin
            r = {4'(c + 3), 4'(c + 2), 4'(c + 1), 4'(c)};
            wr(OFF_ROP, {16'h0, r});
            op(1'b0, 1'b0, 11'h0, 11'h0, S0, D0);
            chk("boolean", bexp(r, S0, D0), rp);
            chk("pixel_we", 128'hffff, 128'(pw));
        end
    endtask

    task automatic t_gate;
        wr(OFF_PLANE, 32'h5a);
        wr(OFF_PIXEL, 32'h8000_0001);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_ROP, {k[1:0], k[1:0], 12'h0, 16'hcccc});
            op(1'b0, 1'b0, 11'h0, 11'h0, '1, '0);
            chk("we", k == 1 ? 128'h0 : k == 2 ? 128'hff_ffff : 128'h5a_0001, 128'({plw, pw}));
        end
        chk("vram", 128'h5a, dst_pixels);
        rchk("plane_gate", OFF_PLANE, 32'h5a, 1'b0);
        rchk("pixel_gate", OFF_PIXEL, 32'h8000_0001, 1'b0);
        wr(OFF_PIXEL, 32'h0000_0003);
        op(1'b0, 1'b0, 11'd16, 11'h0, S0, D0);
        chk("pixel_we", 128'hc000, 128'(pw));
        wr(OFF_CONFIG, 32'h5);
        wr(OFF_PIXEL, 32'h0003_0000);
        op(1'b0, 1'b0, 11'd16, 11'h0, S0, D0);
        chk("pixel_we", 128'h0003, 128'(pw));
    endtask

    task automatic t_lin;
        wr(OFF_FG, 32'hfe);
        wr(OFF_BG, 32'h0);
        wr(OFF_PIXEL, 32'hffff_ffff);
        for (int u = 0; u < 2; u++) begin
            wr(OFF_CONFIG, u ? 32'h9 : 32'h1);
            for (int c = 0; c < 16; c++) begin
                wr(OFF_ROP, {16'h0, 12'haaa, 4'(c)});
                op(1'b1, 1'b0, 11'h0, 11'h0, S1, D0);
                for (int i = 0; i < 16; i++) e[8*i +: 8] = lexp(4'(c), u[0], D0[8*i +: 8], S1[8*i +: 8]);
                chk("linear", e, rp);
                rchk("flag", OFF_STATUS, 32'(c inside {1, 3, 4, 7, 12, 13}), 1'b0);
                wr(OFF_STATUS, 32'h1);
            end
        end
        // refused code 1100 done in two steps: clear, then saturating add
        wr(OFF_ROP, 32'h0);
        op(1'b0, 1'b0, 11'h0, 11'h0, S1, D0);
        wr(OFF_ROP, 32'he);
        op(1'b1, 1'b0, 11'h0, 11'h0, S1, rp);
        for (int i = 0; i < 16; i++) e[8*i +: 8] = {1'b0, S1[8*i +: 7]};
        chk("emulated", e, rp);
    endtask

    task automatic t_pat;
        wr(OFF_CONFIG, 32'h1);
        wr(OFF_ALIGN, 32'h0003_0001);
        wr(8'h24, 32'h1234_a5c3);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_ROP, {4'h0, k[1:0], 10'h0, 16'hcccc});
            op(1'b0, 1'b1, 11'h0, 11'h4, S0, D0);
            for (int i = 0; i < 16; i++) e[8*i +: 8] = {8{k == 1 ? 1'b0 : k == 2 ? 1'b1 : PR[15 - (i + 13) % 16]}};
            chk("pattern", e, rp);
        end
        rchk("pattern_reg", 8'h24, 32'h1234_a5c3, 1'b0);
    endtask

    task automatic t_sub;
        wr(OFF_CONFIG, 32'h2);
        wr(OFF_ROP, 32'h0000_cccc);
        op(1'b0, 1'b0, 11'h0, 11'h0, S0, D0);
        for (int i = 0; i < 16; i++) e[8*i +: 8] = {8{S0[8*i]}};
        chk("expand", e, rp);
        wr(OFF_CONFIG, 32'h3);
        wr(OFF_ROP, 32'h0000_aaae);
        src_subpixels <= SS;
        clip_subpixels <= SC;
        op(1'b1, 1'b0, 11'h0, 11'h0, S0, D0);
        for (int i = 0; i < 16; i++) e[8*i +: 8] = lexp(4'he, 1'b0, D0[8*i +: 8], 8'($countones(SS[4*i +: 4] & SC[4*i +: 4]) * FLAT_WEIGHT));
        chk("subpixel", e, rp);
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, op_valid, op_linear, op_use_pattern, ld} = '0;
        {paddr, pwdata, op_x, op_y, src_pixels, src_subpixels, clip_subpixels, ld_data} = '0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_bool;
        t_gate;
        t_lin;
        t_pat;
        t_sub;
        conclude;
    end

    initial begin
        repeat (10000) @(posedge sys_clk);
        n_fail++;
        conclude;
    end
endmodule
`default_nettype wire
